// *** hw/iss_exec.sv ***
// What this block does
// - Register logical right shift: source A shifted right by B, zeros in, write rD.
// - Register shift uses only low five count bits; bit 5 ignored.
// - Immediate logical right shift by low 5 bits of immediate field, zero fill, write rD.
// - Immediate shift ignores immediate bit 5; low five bits only.
// - Subtract writes source A minus source B to rD.
// - Subtract writes the overflow flag from signed overflow of A minus B.
// - Word store address is sign-extended split offset plus base register.
// - Word store writes low 32 bits of source B to memory.
// - System call always raises its exception carrying the 16-bit service code.
// - Trap raises exception only when the selected supervision bit is one.
// - Register XOR writes A xor B to rD.
// - Immediate XOR sign-extends the immediate, xors with A, writes rD.
// - Floating add single adds sources; double form absent at 32 bits.
// - Single add works on low 32 bits of the sources.
// - Custom float slots have no defined behaviour; only flagged.
`timescale 1ns/10ps
module iss_exec (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Issue
  input wire logic issue_valid,
  input wire logic [31:0] insn,
  input wire logic [iss_pkg::XLEN-1:0] src_reg_a,
  input wire logic [iss_pkg::XLEN-1:0] src_reg_b,
  input wire logic [iss_pkg::SR_W-1:0] supervision_register,
  input wire logic range_exc_en,
  // Load/store unit fault
  input wire logic store_fault,
  // Register write
  output logic rf_we_q,
  output logic [iss_pkg::RIDX_W-1:0] rf_waddr_q,
  output logic [iss_pkg::XLEN-1:0] rf_wdata_q,
  // Flag update
  output logic overflow_flag_we_q,
  output logic overflow_flag_q,
  // Store request
  output logic store_word_q,
  output logic [iss_pkg::XLEN-1:0] effective_address_q,
  output logic [31:0] store_data_q,
  // Exceptions
  output logic exc_syscall_q,
  output logic exc_trap_q,
  output logic exc_range_q,
  output logic exc_align_q,
  output logic exc_fault_q,
  output logic exc_fp_q,
  output logic exc_illegal_q,
  output logic [iss_pkg::IMM_W-1:0] exc_code_q,
  output logic fp_custom_single_slot_q,
  output logic fp_custom_double_slot_q
);
  import iss_pkg::*;

  // ==========================================
  // Decode
  logic [OP_W-1:0] opc;
  logic [15:0] hi16;
  logic [IMM_W-1:0] imm16;
  logic [IMM_W-1:0] sw_off;
  logic [XLEN-1:0] imm_sx;
  logic [XLEN-1:0] sw_sx;
  logic is_srl, is_srli, is_sub, is_xor, is_xori, is_sw, is_sys, is_trap;
  logic is_fadd_s, is_fadd_d, is_cust_s, is_cust_d;
  logic [31:0] fp_sum;
  logic fp_ovf, fp_inv;

  assign opc = insn[OP_LSB +: OP_W];
  assign hi16 = insn[HI16_LSB +: 16];
  assign imm16 = insn[IMM_W-1:0];
  assign sw_off = {insn[RD_LSB +: SW_HI_W], insn[SW_LO_W-1:0]};
  assign imm_sx = {{(XLEN-IMM_W){imm16[IMM_SIGN]}}, imm16};
  assign sw_sx = {{(XLEN-IMM_W){sw_off[IMM_SIGN]}}, sw_off};
  assign is_srl = opc == OPC_ALU && insn[ALU_SUB_LSB +: ALU_SUB_W] == ALU_SHIFT
                  && insn[SH_SUB_LSB +: SH_SUB_W] == SH_SRL;
  assign is_sub = opc == OPC_ALU && insn[ALU_SUB_LSB +: ALU_SUB_W] == ALU_SUB;
  assign is_xor = opc == OPC_ALU && insn[ALU_SUB_LSB +: ALU_SUB_W] == ALU_XOR;
  assign is_srli = opc == OPC_SHI && insn[SH_SUB_LSB +: SH_SUB_W] == SH_SRL;
  assign is_xori = opc == OPC_XORI;
  assign is_sw = opc == OPC_SW;
  assign is_sys = hi16 == SYS_HI;
  assign is_trap = hi16 == TRAP_HI;
  assign is_fadd_s = opc == OPC_FP && insn[FP_SUB_LSB +: FP_SUB_W] == FP_ADD_S;
  assign is_fadd_d = opc == OPC_FP && insn[FP_SUB_LSB +: FP_SUB_W] == FP_ADD_D;
  assign is_cust_s = opc == OPC_FP && insn[FP_CUST_LSB +: FP_CUST_W] == FP_CUST_S;
  assign is_cust_d = opc == OPC_FP && insn[FP_CUST_LSB +: FP_CUST_W] == FP_CUST_D;

  iss_fp_add u_fp_add (
    .a(src_reg_a[31:0]),
    .b(src_reg_b[31:0]),
    .sum(fp_sum),
    .ovf(fp_ovf),
    .inv(fp_inv)
  );

  // ==========================================
  // Execute
  logic rf_we_d;
  logic [RIDX_W-1:0] rf_waddr_d;
  logic [XLEN-1:0] rf_wdata_d;
  logic ov_we_d, ov_d;
  logic st_d;
  logic [XLEN-1:0] ea_d;
  logic [31:0] sd_d;
  logic sys_d, trap_d, range_d, align_d, fault_d, fp_d, ill_d, cs_d, cd_d;
  logic [IMM_W-1:0] code_d;
  logic [XLEN-1:0] diff;
  logic sub_ovf;
  logic [XLEN-1:0] ea_calc;

  assign diff = src_reg_a - src_reg_b;
  assign sub_ovf = (src_reg_a[XLEN-1] != src_reg_b[XLEN-1])
                   && (diff[XLEN-1] != src_reg_a[XLEN-1]);
  assign ea_calc = sw_sx + src_reg_a;

  always_comb begin
    rf_we_d = 1'b0;
    rf_waddr_d = insn[RD_LSB +: RIDX_W];
    rf_wdata_d = rf_wdata_q;
    ov_we_d = 1'b0;
    ov_d = overflow_flag_q;
    st_d = 1'b0;
    ea_d = effective_address_q;
    sd_d = store_data_q;
    sys_d = 1'b0;
    trap_d = 1'b0;
    range_d = 1'b0;
    align_d = 1'b0;
    fault_d = store_fault;
    fp_d = 1'b0;
    ill_d = 1'b0;
    cs_d = 1'b0;
    cd_d = 1'b0;
    code_d = exc_code_q;
    if (issue_valid) begin
      if (is_sys) begin
        sys_d = 1'b1;
        code_d = imm16;
      end else if (is_trap) begin
        code_d = imm16;
        trap_d = (imm16 < SR_W) && supervision_register[imm16[RIDX_W-1:0]];
      end else if (is_srl) begin
        rf_we_d = 1'b1;
        rf_wdata_d = src_reg_a >> src_reg_b[SHAMT_W-1:0];
      end else if (is_srli) begin
        rf_we_d = 1'b1;
        rf_wdata_d = src_reg_a >> insn[SHAMT_W-1:0];
      end else if (is_sub) begin
        rf_we_d = 1'b1;
        rf_wdata_d = diff;
        ov_we_d = 1'b1;
        ov_d = sub_ovf;
        range_d = sub_ovf && range_exc_en;
      end else if (is_xor) begin
        rf_we_d = 1'b1;
        rf_wdata_d = src_reg_a ^ src_reg_b;
      end else if (is_xori) begin
        rf_we_d = 1'b1;
        rf_wdata_d = src_reg_a ^ imm_sx;
      end else if (is_sw) begin
        ea_d = ea_calc;
        sd_d = src_reg_b[31:0];
        if (ea_calc[1:0] != WORD_ALIGN) begin
          align_d = 1'b1;
        end else begin
          st_d = 1'b1;
        end
      end else if (is_fadd_s) begin
        rf_we_d = 1'b1;
        rf_wdata_d = fp_sum;
        fp_d = fp_ovf || fp_inv;
      end else if (is_cust_s) begin
        cs_d = 1'b1;
      end else if (is_cust_d) begin
        cd_d = 1'b1;
      end else begin
        ill_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rf_we_q <= 1'b0;
      rf_waddr_q <= '0;
      rf_wdata_q <= '0;
      overflow_flag_we_q <= 1'b0;
      overflow_flag_q <= 1'b0;
      store_word_q <= 1'b0;
      effective_address_q <= '0;
      store_data_q <= 32'h00000000;
      exc_syscall_q <= 1'b0;
      exc_trap_q <= 1'b0;
      exc_range_q <= 1'b0;
      exc_align_q <= 1'b0;
      exc_fault_q <= 1'b0;
      exc_fp_q <= 1'b0;
      exc_illegal_q <= 1'b0;
      exc_code_q <= '0;
      fp_custom_single_slot_q <= 1'b0;
      fp_custom_double_slot_q <= 1'b0;
    end else begin
      rf_we_q <= rf_we_d;
      rf_waddr_q <= rf_waddr_d;
      rf_wdata_q <= rf_wdata_d;
      overflow_flag_we_q <= ov_we_d;
      overflow_flag_q <= ov_d;
      store_word_q <= st_d;
      effective_address_q <= ea_d;
      store_data_q <= sd_d;
      exc_syscall_q <= sys_d;
      exc_trap_q <= trap_d;
      exc_range_q <= range_d;
      exc_align_q <= align_d;
      exc_fault_q <= fault_d;
      exc_fp_q <= fp_d;
      exc_illegal_q <= ill_d;
      exc_code_q <= code_d;
      fp_custom_single_slot_q <= cs_d;
      fp_custom_double_slot_q <= cd_d;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_srl;
    issue_valid && is_srl && !is_sys && !is_trap |=>
      rf_we_q && rf_wdata_q == ($past(src_reg_a) >> $past(src_reg_b[SHAMT_W-1:0]));
  endproperty
  a_srl: assert property (p_srl) else $error("srl result wrong");

  property p_srl_bit5;
    issue_valid && is_srl && !is_sys && !is_trap && src_reg_b[SHAMT_BIT5]
      && src_reg_b[SHAMT_W-1:0] == '0 |=> rf_wdata_q == $past(src_reg_a);
  endproperty
  a_srl_bit5: assert property (p_srl_bit5) else $error("srl bit5 not ignored");

  property p_srli;
    issue_valid && is_srli && !is_sys && !is_trap |=>
      rf_we_q && rf_wdata_q == ($past(src_reg_a) >> $past(insn[SHAMT_W-1:0]));
  endproperty
  a_srli: assert property (p_srli) else $error("srli result wrong");

  property p_srli_bit5;
    issue_valid && is_srli && !is_sys && !is_trap && insn[SHAMT_BIT5]
      && insn[SHAMT_W-1:0] == '0 |=> rf_wdata_q == $past(src_reg_a);
  endproperty
  a_srli_bit5: assert property (p_srli_bit5) else $error("srli bit5 not ignored");

  property p_sub;
    issue_valid && is_sub && !is_sys && !is_trap |=>
      rf_we_q && overflow_flag_we_q && rf_wdata_q == $past(src_reg_a) - $past(src_reg_b);
  endproperty
  a_sub: assert property (p_sub) else $error("sub result wrong");

  property p_range;
    exc_range_q |-> $past(range_exc_en) && overflow_flag_q && overflow_flag_we_q;
  endproperty
  a_range: assert property (p_range) else $error("range without overflow");

  property p_store;
    store_word_q |-> effective_address_q[1:0] == WORD_ALIGN && !exc_align_q
      && store_data_q == $past(src_reg_b[31:0]);
  endproperty
  a_store: assert property (p_store) else $error("store wrong");

  property p_ea;
    issue_valid && is_sw && !is_sys && !is_trap |=>
      effective_address_q == $past(ea_calc) && (store_word_q ^ exc_align_q);
  endproperty
  a_ea: assert property (p_ea) else $error("store address wrong");

  property p_sys;
    issue_valid && is_sys |=> exc_syscall_q && exc_code_q == $past(imm16) && !rf_we_q;
  endproperty
  a_sys: assert property (p_sys) else $error("syscall missing");

  property p_trap;
    exc_trap_q |-> $past(is_trap) && $past(supervision_register[imm16[RIDX_W-1:0]]);
  endproperty
  a_trap: assert property (p_trap) else $error("trap without bit");

  property p_xori;
    issue_valid && is_xori && !is_sys && !is_trap |=>
      rf_wdata_q == ($past(src_reg_a) ^ $past(imm_sx));
  endproperty
  a_xori: assert property (p_xori) else $error("xori wrong");

  c_srl: cover property (issue_valid && is_srl ##1 rf_we_q);
  c_sub_ovf: cover property (exc_range_q);
  c_align: cover property (exc_align_q);
  c_trap: cover property (exc_trap_q);
endmodule

// *** hw/iss_pkg.sv ***
package iss_pkg;
  // ==========================================
  // Data widths
  localparam int XLEN = 32;
  localparam int SR_W = 32;
  localparam int RIDX_W = 5;
  localparam int IMM_W = 16;
  localparam int SHAMT_W = 5;
  // ==========================================
  // Instruction field positions
  localparam int OP_LSB = 26;
  localparam int OP_W = 6;
  localparam int RD_LSB = 21;
  localparam int RA_LSB = 16;
  localparam int RB_LSB = 11;
  localparam int ALU_SUB_LSB = 0;
  localparam int ALU_SUB_W = 4;
  localparam int SH_SUB_LSB = 6;
  localparam int SH_SUB_W = 2;
  localparam int FP_SUB_LSB = 0;
  localparam int FP_SUB_W = 8;
  localparam int FP_CUST_LSB = 4;
  localparam int FP_CUST_W = 4;
  localparam int HI16_LSB = 16;
  localparam int SW_LO_W = 11;
  localparam int SW_HI_W = 5;
  localparam int IMM_SIGN = 15;
  localparam int SHAMT_BIT5 = 5;
  // ==========================================
  // Opcodes
  localparam logic [5:0] OPC_ALU = 6'h38;
  localparam logic [5:0] OPC_SHI = 6'h2E;
  localparam logic [5:0] OPC_SW = 6'h35;
  localparam logic [5:0] OPC_FP = 6'h32;
  localparam logic [5:0] OPC_XORI = 6'h2F;
  localparam logic [3:0] ALU_SHIFT = 4'h8;
  localparam logic [3:0] ALU_XOR = 4'h5;
  localparam logic [3:0] ALU_SUB = 4'h2;
  localparam logic [1:0] SH_SRL = 2'h1;
  localparam logic [7:0] FP_ADD_S = 8'h00;
  localparam logic [7:0] FP_ADD_D = 8'h10;
  localparam logic [3:0] FP_CUST_S = 4'hD;
  localparam logic [3:0] FP_CUST_D = 4'hE;
  localparam logic [15:0] SYS_HI = 16'h2000;
  localparam logic [15:0] TRAP_HI = 16'h2100;
  localparam logic [1:0] WORD_ALIGN = 2'h0;
  // ==========================================
  // Single-precision layout
  localparam logic [7:0] EXP_MAX = 8'hFF;
  localparam logic [31:0] QNAN = 32'h7FC00000;
  localparam logic [30:0] INF_MAG = 31'h7F800000;
endpackage

`timescale 1ns/10ps
module iss_fp_add (
  // Operands
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  // Result and conditions
  output logic [31:0] sum,
  output logic ovf,
  output logic inv
);
  import iss_pkg::*;

  always_comb begin
    logic big_a;
    logic sl;
    logic ss;
    logic [7:0] el;
    logic [7:0] es;
    logic [7:0] diff;
    logic [23:0] ml;
    logic [23:0] ms;
    logic [26:0] al;
    logic [26:0] as_;
    logic [27:0] raw;
    logic [26:0] r;
    logic [8:0] e;
    logic a_spc;
    logic b_spc;
    big_a = 1'b0;
    sl = 1'b0;
    ss = 1'b0;
    el = 8'h00;
    es = 8'h00;
    diff = 8'h00;
    ml = 24'h000000;
    ms = 24'h000000;
    al = 27'h0000000;
    as_ = 27'h0000000;
    raw = 28'h0000000;
    r = 27'h0000000;
    e = 9'h000;
    sum = 32'h00000000;
    ovf = 1'b0;
    inv = 1'b0;
    a_spc = (a[30:23] == EXP_MAX);
    b_spc = (b[30:23] == EXP_MAX);
    big_a = (a[30:0] >= b[30:0]);
    // Larger magnitude first; subnormal operands flush to zero
    sl = big_a ? a[31] : b[31];
    ss = big_a ? b[31] : a[31];
    el = big_a ? a[30:23] : b[30:23];
    es = big_a ? b[30:23] : a[30:23];
    ml = (el == 8'h00) ? 24'h000000 : {1'b1, (big_a ? a[22:0] : b[22:0])};
    ms = (es == 8'h00) ? 24'h000000 : {1'b1, (big_a ? b[22:0] : a[22:0])};
    diff = el - es;
    al = {ml, 3'h0};
    as_ = (diff > 8'd26) ? 27'h0000000 : ({ms, 3'h0} >> diff);
    raw = (sl == ss) ? ({1'b0, al} + {1'b0, as_}) : ({1'b0, al} - {1'b0, as_});
    e = {1'b0, el};
    if (raw[27]) begin
      r = raw[27:1];
      e = e + 9'd1;
    end else begin
      r = raw[26:0];
      for (int i = 0; i < 26; i++) begin
        if (!r[26] && r != 27'h0000000 && e > 9'd1) begin
          r = r << 1;
          e = e - 9'd1;
        end
      end
    end
    if (r == 27'h0000000) begin
      sum = 32'h00000000;
    end else if (e >= {1'b0, EXP_MAX}) begin
      sum = {sl, INF_MAG};
      ovf = 1'b1;
    end else if (!r[26]) begin
      sum = {sl, 8'h00, r[25:3]};
    end else begin
      sum = {sl, e[7:0], r[25:3]};
    end
    // NaN and infinity operands
    if (a_spc || b_spc) begin
      ovf = 1'b0;
      if ((a_spc && a[22:0] != 23'h000000) || (b_spc && b[22:0] != 23'h000000)
          || (a_spc && b_spc && a[31] != b[31])) begin
        sum = QNAN;
        inv = 1'b1;
      end else begin
        sum = a_spc ? a : b;
      end
    end
  end
endmodule

// *** bench/iss_exec_tb.sv ***
`timescale 1ns/10ps
module iss_exec_tb;
  import iss_pkg::*;
  // ==========================================
  // Expected result
  typedef struct packed {
    logic we;
    logic [31:0] wd;
    logic ovwe;
    logic ov;
    logic st;
    logic [31:0] ea;
    logic [31:0] sd;
    logic sys;
    logic trp;
    logic rng;
    logic aln;
    logic fp;
    logic ill;
    logic [15:0] code;
    logic cs;
    logic cd;
  } iss_exp_t;
  // ==========================================
  // Signals
  logic ref_clk, rst, issue_valid, range_exc_en, store_fault;
  logic [31:0] insn, src_reg_a, src_reg_b, supervision_register;
  logic rf_we_q, overflow_flag_we_q, overflow_flag_q, store_word_q;
  logic [4:0] rf_waddr_q;
  logic [31:0] rf_wdata_q, effective_address_q, store_data_q;
  logic exc_syscall_q, exc_trap_q, exc_range_q, exc_align_q, exc_fault_q;
  logic exc_fp_q, exc_illegal_q, cs_q, cd_q;
  logic [15:0] exc_code_q;
  logic [31:0] fp_sum, i, a, b, r;
  logic fp_exc, fp_data;
  int mismatches, n_compared, n, k;
  integer seed;
  // ==========================================
  // Device
  iss_exec u_dut (
    .ref_clk(ref_clk), .rst(rst), .issue_valid(issue_valid), .insn(insn),
    .src_reg_a(src_reg_a), .src_reg_b(src_reg_b),
    .supervision_register(supervision_register), .range_exc_en(range_exc_en),
    .store_fault(store_fault), .rf_we_q(rf_we_q), .rf_waddr_q(rf_waddr_q),
    .rf_wdata_q(rf_wdata_q), .overflow_flag_we_q(overflow_flag_we_q),
    .overflow_flag_q(overflow_flag_q), .store_word_q(store_word_q),
    .effective_address_q(effective_address_q), .store_data_q(store_data_q),
    .exc_syscall_q(exc_syscall_q), .exc_trap_q(exc_trap_q), .exc_range_q(exc_range_q),
    .exc_align_q(exc_align_q), .exc_fault_q(exc_fault_q), .exc_fp_q(exc_fp_q),
    .exc_illegal_q(exc_illegal_q), .exc_code_q(exc_code_q),
    .fp_custom_single_slot_q(cs_q), .fp_custom_double_slot_q(cd_q)
  );
  // ==========================================
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ==========================================
  // Reference
  function automatic iss_exp_t predict(logic [31:0] x, logic [31:0] p, logic [31:0] q,
      logic [31:0] sr, logic ren);
    iss_exp_t e;
    logic [31:0] d;
    e = '0;
    d = p - q;
    e.ea = p + {{16{x[25]}}, x[25:21], x[10:0]};
    if (x[31:16] == SYS_HI) begin
      e.sys = 1'b1;
      e.code = x[15:0];
    end else if (x[31:16] == TRAP_HI) begin
      e.trp = (x[15:0] < 16'h0020) && sr[x[4:0]];
      e.code = x[15:0];
    end else if (x[31:26] == OPC_ALU && x[3:0] == ALU_SHIFT && x[7:6] == SH_SRL) begin
      e.we = 1'b1;
      e.wd = p >> q[4:0];
    end else if (x[31:26] == OPC_SHI && x[7:6] == SH_SRL) begin
      e.we = 1'b1;
      e.wd = p >> x[4:0];
    end else if (x[31:26] == OPC_ALU && x[3:0] == ALU_SUB) begin
      e.we = 1'b1;
      e.wd = d;
      e.ovwe = 1'b1;
      e.ov = (p[31] != q[31]) && (d[31] != p[31]);
      e.rng = e.ov & ren;
    end else if (x[31:26] == OPC_ALU && x[3:0] == ALU_XOR) begin
      e.we = 1'b1;
      e.wd = p ^ q;
    end else if (x[31:26] == OPC_XORI) begin
      e.we = 1'b1;
      e.wd = p ^ {{16{x[15]}}, x[15:0]};
    end else if (x[31:26] == OPC_SW) begin
      e.aln = e.ea[1:0] != WORD_ALIGN;
      e.st = !e.aln;
      e.sd = q;
    end else if (x[31:26] == OPC_FP && x[7:0] == FP_ADD_S) begin
      e.we = 1'b1;
      e.wd = fp_sum;
      e.fp = fp_exc;
    end else if (x[31:26] == OPC_FP && x[7:4] == FP_CUST_S) begin
      e.cs = 1'b1;
    end else if (x[31:26] == OPC_FP && x[7:4] == FP_CUST_D) begin
      e.cd = 1'b1;
    end else begin
      e.ill = 1'b1;
    end
    return e;
  endfunction
  // ==========================================
  // Compare
  task automatic chk_b(input logic got, input logic exp, input string m);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: %s got %b exp %b", $time, m, got, exp);
    end
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // ==========================================
  // One issue, checked one edge later
  task automatic run(input logic [31:0] x, p, q, sr, input logic ren, flt);
    iss_exp_t e;
    e = predict(x, p, q, sr, ren);
    insn = x;
    src_reg_a = p;
    src_reg_b = q;
    supervision_register = sr;
    range_exc_en = ren;
    store_fault = flt;
    issue_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    chk_w({27'h0, rf_waddr_q}, {27'h0, x[25:21]}, "waddr");
    if (fp_data) chk_b(rf_we_q, e.we, "we");
    if (fp_data && e.we) chk_w(rf_wdata_q, e.wd, "wdata");
    chk_b(overflow_flag_we_q, e.ovwe, "ov we");
    if (e.ovwe) chk_b(overflow_flag_q, e.ov, "ov");
    chk_b(exc_range_q, e.rng, "range");
    chk_b(store_word_q, e.st, "store");
    if (e.st || e.aln) chk_w(effective_address_q, e.ea, "ea");
    if (e.st) chk_w(store_data_q, e.sd, "sdata");
    chk_b(exc_align_q, e.aln, "align");
    chk_b(exc_fault_q, flt, "fault");
    chk_b(exc_syscall_q, e.sys, "sys");
    chk_b(exc_trap_q, e.trp, "trap");
    if (x[31:16] == SYS_HI || x[31:16] == TRAP_HI) chk_w({16'h0, exc_code_q}, {16'h0, e.code}, "code");
    chk_b(exc_fp_q, e.fp, "fp exc");
    chk_b(exc_illegal_q, e.ill, "illegal");
    chk_b(cs_q, e.cs, "cust s");
    chk_b(cd_q, e.cd, "cust d");
  endtask
  task automatic fadd(input logic [31:0] p, q, s, input logic ex, dat);
    fp_sum = s;
    fp_exc = ex;
    fp_data = dat;
    run({OPC_FP, 15'h0843, 3'h0, FP_ADD_S}, p, q, 32'h0, 1'b0, 1'b0);
    fp_data = 1'b1;
  endtask
  task automatic results;
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // Sequence
  initial begin
    seed = 46;
    mismatches = 0;
    n_compared = 0;
    fp_data = 1'b1;
    fp_exc = 1'b0;
    fp_sum = 32'h0;
    rst = 1'b1;
    issue_valid = 1'b0;
    insn = 32'h0;
    src_reg_a = 32'h0;
    src_reg_b = 32'h0;
    supervision_register = 32'h0;
    range_exc_en = 1'b0;
    store_fault = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    @(posedge ref_clk);
    #1;
    chk_b(rf_we_q | store_word_q | exc_illegal_q | exc_syscall_q, 1'b0, "reset");
    // Corner cases
    run({OPC_ALU, 15'h0443, 11'h048}, 32'h80000000, 32'h0000003F, 0, 0, 0);
    run({OPC_ALU, 15'h0443, 11'h048}, 32'hF0F0F0F0, 32'h00000020, 0, 0, 1);
    run({OPC_SHI, 10'h041, 8'h00, SH_SRL, 6'h3F}, 32'hFFFFFFFF, 0, 0, 0, 0);
    run({OPC_SHI, 10'h041, 8'h00, SH_SRL, 6'h24}, 32'h80000000, 0, 0, 0, 0);
    run({OPC_ALU, 15'h0443, 11'h002}, 32'h80000000, 32'h1, 0, 1, 0);
    run({OPC_ALU, 15'h0443, 11'h002}, 32'h7FFFFFFF, 32'hFFFFFFFF, 0, 0, 0);
    run({OPC_XORI, 10'h041, 16'h8000}, 32'h12345678, 0, 0, 0, 0);
    run({OPC_SW, 5'h1F, 10'h000, 11'h7FC}, 32'h100, 32'hCAFEF00D, 0, 0, 0);
    run({OPC_SW, 5'h00, 10'h000, 11'h002}, 32'h100, 32'h1, 0, 0, 0);
    run({TRAP_HI, 16'h001F}, 0, 0, 32'h80000000, 0, 0);
    run({TRAP_HI, 16'h0020}, 0, 0, 32'hFFFFFFFF, 0, 0);
    run({SYS_HI, 16'hFFFF}, 0, 0, 0, 0, 0);
    fadd(32'h3F800000, 32'h40000000, 32'h40400000, 1'b0, 1'b1);
    fadd(32'h3F800000, 32'hBF800000, 32'h00000000, 1'b0, 1'b1);
    fadd(32'h7F7FFFFF, 32'h7F7FFFFF, 32'h0, 1'b1, 1'b0);
    fadd(32'h7F800000, 32'hFF800000, 32'h0, 1'b1, 1'b0);
    fadd(32'h7FC00000, 32'h3F800000, 32'h0, 1'b1, 1'b0);
    // Random back-to-back traffic
    for (n = 0; n < 800; n++) begin
      k = $unsigned($random(seed)) % 10;
      a = $random(seed);
      b = $random(seed);
      r = $random(seed);
      i = $random(seed);
      case (k)
        0: i = {OPC_ALU, i[25:11], 11'h048};
        1: i = {OPC_SHI, i[25:16], 8'h00, SH_SRL, i[5:0]};
        2: i = {OPC_ALU, i[25:11], 11'h002};
        3: i = {OPC_ALU, i[25:11], 11'h005};
        4: i = {OPC_XORI, i[25:0]};
        5: i = {OPC_SW, i[25:0]};
        6: i = {SYS_HI, i[15:0]};
        7: i = {TRAP_HI, 10'h000, i[5:0]};
        8: i = {OPC_FP, i[25:11], 3'h0, r[0] ? FP_CUST_S : FP_CUST_D, 4'h0};
        default: i = r[2] ? {6'h3F, i[25:0]} : {OPC_FP, i[25:11], 3'h0, FP_ADD_D};
      endcase
      if (k == 5 && r[1]) begin
        a[1:0] = 2'b00;
        i[1:0] = 2'b00;
      end
      run(i, a, b, r, a[0], b[0]);
    end
    issue_valid = 1'b0;
    results();
  end
endmodule
